// ### include/plglu_pkg.sv
package plglu_pkg;

  // ************************************************************
  // geometry
  // ************************************************************
  localparam int PLGLU_UNITS   = 4;
  localparam int PLGLU_INS     = 4;
  localparam int PLGLU_PINS    = PLGLU_UNITS * PLGLU_INS;
  localparam int PLGLU_TRUTH_W = 16;
  localparam int PLGLU_ADDR_W  = 8;
  localparam int PLGLU_DATA_W  = 32;
  localparam int PLGLU_SEL_W   = 2;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] PLGLU_CTRL_BASE  = 8'h00;
  localparam logic [7:0] PLGLU_TRUTH_BASE = 8'h04;
  localparam logic [7:0] PLGLU_MAP_END    = 8'h20;
  localparam logic [7:0] PLGLU_FCLK_OFF   = 8'h30;
  localparam logic [7:0] PLGLU_PARAM_OFF  = 8'h38;
  localparam logic [7:0] PLGLU_VER_OFF    = 8'h3c;
  localparam logic [2:0] PLGLU_SLOT_MASK  = 3'h7;
  localparam int         PLGLU_SEL_LSB    = 3;

  // ************************************************************
  // fields
  // ************************************************************
  localparam int PLGLU_FILT_ON_BIT = 31;
  localparam int PLGLU_MASK_LSB    = 0;
  localparam int PLGLU_FCLK_EN    = 0;
  localparam int PLGLU_FDIV_LSB   = 8;
  localparam int PLGLU_FDIV_W     = 8;
  localparam int PLGLU_VER_LSB    = 0;
  localparam int PLGLU_VER_W      = 12;
  localparam int PLGLU_VAR_LSB    = 16;
  localparam int PLGLU_VAR_W      = 4;

  // ************************************************************
  // reset and fixed values
  // ************************************************************
  localparam logic [31:0] PLGLU_ZERO      = 32'h0000_0000;
  localparam logic [31:0] PLGLU_PARAM_VAL = 32'h0000_0004;
  localparam logic [3:0]  PLGLU_MASK_RST  = 4'h0;
  localparam logic [15:0] PLGLU_TRUTH_RST = 16'h0000;
  localparam logic [7:0]  PLGLU_FDIV_RST  = 8'h00;

  // ************************************************************
  // filter timing, in filter clock ticks
  // ************************************************************
  localparam int PLGLU_FILT_MIN_TICKS = 3;
  localparam int PLGLU_FILT_MAX_TICKS = 4;

  function automatic logic plglu_slot_hit(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] rel;
    rel = a - base;
    return (a >= base) && (a < PLGLU_MAP_END) && (rel[2:0] == 3'h0);
  endfunction

  function automatic logic [PLGLU_SEL_W-1:0] plglu_sel(input logic [7:0] a);
    return a[PLGLU_SEL_LSB +: PLGLU_SEL_W];
  endfunction

endpackage

// ### src/plglu_unit.sv
module plglu_unit
  import plglu_pkg::*;
(
  input  wire logic                     clk_sys,
  input  wire logic                     rst_b,
  input  wire logic [PLGLU_INS-1:0]     lut_input,
  input  wire logic [PLGLU_INS-1:0]     input_enable_mask,
  input  wire logic [PLGLU_TRUTH_W-1:0] lut_truth_table,
  input  wire logic                     output_filter_enable,
  input  wire logic                     filter_tick,
  output wire logic                     lut_output
);

  // ************************************************************
  // lookup
  // ************************************************************
  wire logic [PLGLU_INS-1:0] index;
  wire logic                 raw;

  // masked inputs read as zero, so all-off selects entry 0
  assign index = lut_input & input_enable_mask;
  assign raw   = lut_truth_table[index];

  // ************************************************************
  // glitch filter
  // ************************************************************
  logic sync1_r;
  logic sync2_r;
  logic hold_r;
  logic filt_r;

  // only advances on filter clock ticks; frozen while that clock is off
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      hold_r  <= 1'b0;
      filt_r  <= 1'b0;
    end else if (filter_tick) begin
      sync1_r <= raw;
      sync2_r <= sync1_r;
      hold_r  <= sync2_r;
      if (sync2_r == hold_r) begin
        filt_r <= hold_r;
      end
    end
  end

  // the unfiltered path has no flop on purpose: it must act like a gate
  assign lut_output = output_filter_enable ? filt_r : raw;

endmodule

// ### src/plglu_top.sv
module plglu_top
  import plglu_pkg::*;
#(
  // arbitrary identification values
  parameter logic [PLGLU_VER_W-1:0] VERSION_NUM = 12'h2a5,
  parameter logic [PLGLU_VAR_W-1:0] VARIANT_NUM = 4'h0
)
(
  input  wire logic                    clk_sys,
  input  wire logic                    rst_b,
  input  wire logic [PLGLU_ADDR_W-1:0] addr,
  input  wire logic [PLGLU_DATA_W-1:0] wr_data,
  input  wire logic                    wr_en,
  input  wire logic                    rd_en,
  output logic      [PLGLU_DATA_W-1:0] rd_data,
  input  wire logic [PLGLU_PINS-1:0]   lut_input,
  output wire logic [PLGLU_UNITS-1:0]  lut_output
);

  // ************************************************************
  // register state
  // ************************************************************
  logic [PLGLU_INS-1:0]     mask_r   [PLGLU_UNITS];
  logic                     filt_on_r[PLGLU_UNITS];
  logic [PLGLU_TRUTH_W-1:0] truth_r [PLGLU_UNITS];
  logic                     fclk_en_r;
  logic [PLGLU_FDIV_W-1:0]  fclk_div_r;
  logic [PLGLU_FDIV_W-1:0]  fclk_cnt_r;
  logic [PLGLU_FDIV_W-1:0]  fclk_cnt_nxt;
  logic                     fclk_tick_r;
  logic [PLGLU_DATA_W-1:0]  rd_data_r;
  logic [PLGLU_DATA_W-1:0]  rd_data_nxt;

  // ************************************************************
  // address decode
  // ************************************************************
  wire logic                   ctrl_hit;
  wire logic                   truth_hit;
  wire logic                   fclk_hit;
  wire logic                   param_hit;
  wire logic                   ver_hit;
  wire logic [PLGLU_SEL_W-1:0] sel;

  assign ctrl_hit  = plglu_slot_hit(addr, PLGLU_CTRL_BASE);
  assign truth_hit = plglu_slot_hit(addr, PLGLU_TRUTH_BASE);
  assign fclk_hit  = (addr == PLGLU_FCLK_OFF);
  assign param_hit = (addr == PLGLU_PARAM_OFF);
  assign ver_hit   = (addr == PLGLU_VER_OFF);
  assign sel       = plglu_sel(addr);

  // ************************************************************
  // read data
  // ************************************************************
  wire logic [PLGLU_DATA_W-1:0] ctrl_word;
  wire logic [PLGLU_DATA_W-1:0] truth_word;
  wire logic [PLGLU_DATA_W-1:0] fclk_word;
  wire logic [PLGLU_DATA_W-1:0] ver_word;

  assign ctrl_word = {filt_on_r[sel], {(PLGLU_FILT_ON_BIT-PLGLU_INS){1'b0}}, mask_r[sel]};
  assign truth_word = {{(PLGLU_DATA_W-PLGLU_TRUTH_W){1'b0}}, truth_r[sel]};
  assign fclk_word = {{(PLGLU_DATA_W-PLGLU_FDIV_LSB-PLGLU_FDIV_W){1'b0}}, fclk_div_r,
                      {(PLGLU_FDIV_LSB-1){1'b0}}, fclk_en_r};
  assign ver_word  = {{(PLGLU_DATA_W-PLGLU_VAR_LSB-PLGLU_VAR_W){1'b0}}, VARIANT_NUM,
                      {(PLGLU_VAR_LSB-PLGLU_VER_W){1'b0}}, VERSION_NUM};

  // unmapped addresses read as zero
  assign rd_data_nxt = !rd_en    ? PLGLU_ZERO :
                       ctrl_hit  ? ctrl_word  :
                       truth_hit ? truth_word :
                       fclk_hit  ? fclk_word  :
                       param_hit ? PLGLU_PARAM_VAL :
                       ver_hit   ? ver_word   :
                       PLGLU_ZERO;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_r <= PLGLU_ZERO;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  assign rd_data = rd_data_r;

  // ************************************************************
  // per-unit configuration registers
  // ************************************************************
  for (genvar u = 0; u < PLGLU_UNITS; u++) begin : g_unit
    wire logic ctrl_wr;
    wire logic truth_wr;

    assign ctrl_wr  = wr_en && ctrl_hit  && (sel == PLGLU_SEL_W'(u));
    assign truth_wr = wr_en && truth_hit && (sel == PLGLU_SEL_W'(u));

    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
        mask_r[u]    <= PLGLU_MASK_RST;
        filt_on_r[u] <= 1'b0;
        truth_r[u]   <= PLGLU_TRUTH_RST;
      end else begin
        if (ctrl_wr) begin
          mask_r[u]    <= wr_data[PLGLU_MASK_LSB +: PLGLU_INS];
          filt_on_r[u] <= wr_data[PLGLU_FILT_ON_BIT];
        end
        if (truth_wr) begin
          truth_r[u] <= wr_data[PLGLU_TRUTH_W-1:0];
        end
      end
    end

    // no debug halt input: the units run on regardless
    plglu_unit u_unit (
      .clk_sys              (clk_sys),
      .rst_b                (rst_b),
      .lut_input            (lut_input[u*PLGLU_INS +: PLGLU_INS]),
      .input_enable_mask    (mask_r[u]),
      .lut_truth_table      (truth_r[u]),
      .output_filter_enable (filt_on_r[u]),
      .filter_tick          (fclk_tick_r),
      .lut_output           (lut_output[u])
    );
  end

  // ************************************************************
  // filter generic clock, as an enable pulse
  // ************************************************************
  wire logic fclk_wr;
  wire logic fclk_wrap;

  assign fclk_wr      = wr_en && fclk_hit;
  assign fclk_wrap    = (fclk_cnt_r == fclk_div_r);
  assign fclk_cnt_nxt = fclk_wrap ? PLGLU_FDIV_RST : fclk_cnt_r + 8'h01;

  // filter stays frozen until software starts this clock
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      fclk_en_r  <= 1'b0;
      fclk_div_r <= PLGLU_FDIV_RST;
    end else if (fclk_wr) begin
      fclk_en_r  <= wr_data[PLGLU_FCLK_EN];
      fclk_div_r <= wr_data[PLGLU_FDIV_LSB +: PLGLU_FDIV_W];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      fclk_cnt_r  <= PLGLU_FDIV_RST;
      fclk_tick_r <= 1'b0;
    end else if (!fclk_en_r) begin
      fclk_cnt_r  <= PLGLU_FDIV_RST;
      fclk_tick_r <= 1'b0;
    end else begin
      fclk_cnt_r  <= fclk_cnt_nxt;
      fclk_tick_r <= fclk_wrap;
    end
  end

endmodule

// ### tb/plglu_properties.sv
module plglu_props
  import plglu_pkg::*;
(
  input wire logic                    clk_sys,
  input wire logic                    rst_b,
  input wire logic [PLGLU_ADDR_W-1:0] addr,
  input wire logic [PLGLU_DATA_W-1:0] wr_data,
  input wire logic                    wr_en,
  input wire logic                    rd_en,
  input wire logic [PLGLU_DATA_W-1:0] rd_data,
  input wire logic [PLGLU_PINS-1:0]   lut_input,
  input wire logic [PLGLU_UNITS-1:0]  lut_output
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // helpers
  // ****
  logic        wrote_r;
  logic [15:0] wd_r;
  logic [7:0]  wa_r;
  wire         truth_hit = (addr[2:0] == 3'h4) && (addr < 8'h20);
  wire         ctrl_hit  = (addr[2:0] == 3'h0) && (addr < 8'h20);
  // any write may move the outputs, so only the untouched state is pinned
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wrote_r <= 1'b0;
      wd_r    <= 16'h0000;
      wa_r    <= 8'h00;
    end else begin
      wrote_r <= wrote_r | wr_en;
      wd_r    <= wr_data[15:0];
      wa_r    <= addr;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_truth_wr;
    wr_en && truth_hit;
  endsequence
  sequence s_same_rd;
    rd_en && (addr == wa_r);
  endsequence
  // ****
  // properties
  // ****
  a_rd_idle_zero: assert property (!rd_en |=> rd_data == 32'h0000_0000)
    else $error("read data not zero outside read");
  a_param_value: assert property (rd_en && addr == 8'h38 |=> rd_data == 32'h0000_0004)
    else $error("unit count wrong");
  a_ver_fields: assert property (rd_en && addr == 8'h3c |=>
    rd_data[31:20] == 12'h000 && rd_data[15:12] == 4'h0) else $error("version spare bits set");
  a_truth_upper: assert property (rd_en && truth_hit |=> rd_data[31:16] == 16'h0000)
    else $error("truth upper bits set");
  a_ctrl_unused: assert property (rd_en && ctrl_hit |=> rd_data[30:4] == 27'h000_0000)
    else $error("control spare bits set");
  a_unmapped_zero: assert property (rd_en && addr >= 8'h40 |=> rd_data == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_truth_readback: assert property (s_truth_wr ##1 s_same_rd |=>
    rd_data[15:0] == $past(wd_r)) else $error("truth readback wrong");
  a_out_reset: assert property (!wrote_r |-> lut_output == 4'h0)
    else $error("output not truth bit 0 after reset");
endmodule

bind plglu_top plglu_props plglu_props_inst (.clk_sys(clk_sys), .rst_b(rst_b), .addr(addr),
  .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .lut_input(lut_input), .lut_output(lut_output));

// ### tb/plglu_board.sv
module plglu_board (
  input  wire logic        clk_sys,
  output logic      [15:0] lut_input
);
  timeunit 1ns;
  timeprecision 100ps;
  initial lut_input = 16'h0000;
  // board levels move only just after a system clock edge
  task automatic set_pins(input logic [15:0] v);
    @(posedge clk_sys);
    lut_input <= v;
  endtask
endmodule

// ### tb/testbench.sv
module testbench
  import plglu_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys      = 1'b0;
  logic        rst_b        = 1'b0;
  logic [7:0]  addr;
  logic [31:0] wr_data;
  logic        wr_en;
  logic        rd_en;
  wire  [31:0] rd_data;
  wire  [15:0] lut_input;
  wire  [3:0]  lut_output;
  int          fail_count   = 0;
  int          total_checks = 0;
  int          cycle_count  = 0;
  // identification values are arbitrary
  plglu_top #(.VERSION_NUM(12'h3c7), .VARIANT_NUM(4'h5)) plglu_top_inst (.clk_sys(clk_sys),
    .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .lut_input(lut_input), .lut_output(lut_output));
  plglu_board board_inst (.clk_sys(clk_sys), .lut_input(lut_input));
  always #12.5 clk_sys = ~clk_sys;
  // ****
  // shared tasks
  // ****
  task automatic results;
    if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk_sys);
    wr_en   <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
    @(posedge clk_sys);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    @(negedge clk_sys);
    chk(nm, ex, rd_data);
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_regs;
    rd(8'h00, 32'h0000_0000, "ctrl0");
    rd(8'h04, 32'h0000_0000, "truth0");
    wr(8'h38, 32'hffff_ffff);
    wr(8'h3c, 32'hffff_ffff);
    rd(8'h38, 32'h0000_0004, "param");
    rd(8'h3c, 32'h0005_03c7, "version");
    rd(8'h40, 32'h0000_0000, "unmapped");
    // filter clock first, so the ctrl2 write below keeps the start-up order
    wr(8'h30, 32'h0000_0001);
    rd(8'h30, 32'h0000_0001, "fclk_ctrl");
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10, 32'h8000_000f, "ctrl2");
    wr(8'h10, 32'h0000_0000);
    // write then read with no gap
    @(posedge clk_sys);
    addr    <= 8'h0c;
    wr_data <= 32'hffff_1234;
    wr_en   <= 1'b1;
    @(posedge clk_sys);
    wr_en   <= 1'b0;
    rd_en   <= 1'b1;
    @(posedge clk_sys);
    rd_en   <= 1'b0;
    @(negedge clk_sys);
    chk("truth1", 32'h0000_1234, rd_data);
  endtask
  task automatic t_index;
    logic [15:0] tt [4] = '{16'h6996, 16'h8001, 16'h0ff0, 16'h3c5a};
    logic [15:0] p;
    for (int n = 0; n < 4; n++) begin
      wr(8'(8 * n), 32'h0000_000f);
      wr(8'(8 * n + 4), {16'h0000, tt[n]});
    end
    for (int i = 0; i < 16; i++) begin
      p = {4'(i), 4'(i ^ 5), 4'(15 - i), 4'(i)};
      board_inst.set_pins(p);
      @(negedge clk_sys);
      for (int n = 0; n < 4; n++)
        chk("lut_output", 32'(tt[n][p[4*n +: 4]]), 32'(lut_output[n]));
    end
  endtask
  task automatic t_mask;
    logic [15:0] tt = 16'ha5c3;
    wr(8'h04, {16'h0000, tt});
    for (int m = 0; m < 16; m++) begin
      wr(8'h00, 32'(m));
      for (int i = 0; i < 16; i++) begin
        board_inst.set_pins({{3{4'(15 - i)}}, 4'(i)});
        @(negedge clk_sys);
        chk("masked", 32'(tt[i & m]), 32'(lut_output[0]));
      end
    end
  endtask
  task automatic t_filter;
    wr(8'h30, 32'h0000_0001);
    wr(8'h00, 32'h8000_0001);
    wr(8'h04, 32'h0000_0002);
    board_inst.set_pins(16'h0000);
    repeat (6) @(posedge clk_sys);
    board_inst.set_pins(16'h0001);
    repeat (3) @(negedge clk_sys);
    chk("filt early", 32'h0000_0000, 32'(lut_output[0]));
    repeat (3) @(negedge clk_sys);
    chk("filt late", 32'h0000_0001, 32'(lut_output[0]));
    board_inst.set_pins(16'h0000);
    board_inst.set_pins(16'h0001);
    repeat (6) begin
      @(negedge clk_sys);
      chk("glitch", 32'h0000_0001, 32'(lut_output[0]));
    end
    wr(8'h00, 32'h0000_0001);
    board_inst.set_pins(16'h0000);
    @(negedge clk_sys);
    chk("unfiltered", 32'h0000_0000, 32'(lut_output[0]));
  endtask
  // divider 1: one filter tick every two system cycles, so latency doubles
  task automatic t_divider;
    wr(8'h30, 32'h0000_0101);
    rd(8'h30, 32'h0000_0101, "fclk_div");
    wr(8'h00, 32'h8000_0001);
    wr(8'h04, 32'h0000_0002);
    board_inst.set_pins(16'h0000);
    repeat (12) @(posedge clk_sys);
    board_inst.set_pins(16'h0001);
    repeat (6) @(negedge clk_sys);
    chk("div early", 32'h0000_0000, 32'(lut_output[0]));
    repeat (3) @(negedge clk_sys);
    chk("div late", 32'h0000_0001, 32'(lut_output[0]));
  endtask
  // ****
  // run
  // ****
  always @(posedge clk_sys) begin
    cycle_count++;
    if (cycle_count == 5000) begin
      fail_count++;
      results;
    end
  end
  initial begin
    addr    = 8'h00;
    wr_data = 32'h0000_0000;
    wr_en   = 1'b0;
    rd_en   = 1'b0;
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_regs;
    t_index;
    t_mask;
    t_filter;
    t_divider;
    results;
  end
endmodule
